// ### hdl/sfdp_pkg.sv
// sfdp_pkg: constants and types for the SFD timing pulse generator
// assumes a single 50 MHz core clock and an AXI4-Lite register port
`default_nettype none
package sfdp_pkg;
  // bus geometry
  localparam int AXI_ADDR_W = 10;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PIN_SELECT = 8'h3E;
  localparam logic [7:0] IDX_PHASE_CONFIG = 8'h3F;
  localparam logic [7:0] IDX_STATUS = 8'h3D;
  // reset values
  localparam logic [15:0] PIN_SELECT_RST = 16'h0004;
  localparam logic [15:0] PHASE_CONFIG_RST = 16'h0000;
  // field positions
  localparam int TX_SEL_LSB = 0;
  localparam int RX_SEL_LSB = 2;
  localparam int PHASE_LSB = 0;
  localparam int STAT_SPEED_BIT = 0;
  localparam int STAT_TX_BUSY_BIT = 1;
  localparam int STAT_RX_BUSY_BIT = 2;
  // pin and path counts
  localparam int NUM_PINS = 4;
  localparam int NUM_PATHS = 2;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PHASE_STEP_NS = 8;
  localparam int PULSE_WIDTH_NS = 40;
  localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // per-path pulse sequencer states
  typedef enum logic [1:0] {
    SFDP_IDLE = 2'b00,
    SFDP_WAIT = 2'b01,
    SFDP_PULSE = 2'b10,
    SFDP_DONE = 2'b11
  } sfdp_state_type;
endpackage
`default_nettype wire

// ### hdl/sfdp_pulse_delay.sv
// sfdp_pulse_delay: one path's delimiter strobe to a delayed fixed-width pulse
// assumes strobe and frame level synchronous to aclk, one strobe per frame
`default_nettype none
module sfdp_pulse_delay
  import sfdp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // path status
  input wire logic speed_ok,
  input wire logic frame_active,
  input wire logic sfd_strobe,
  input wire logic [3:0] phase_steps,
  // pulse out
  output logic pulse_o,
  output logic busy_o
);
  sfdp_state_type state_r, state_nxt;
  logic [7:0] elapsed_r, elapsed_nxt;
  logic [1:0] wid_r, wid_nxt;
  logic pulse_nxt;
  logic [7:0] ph_ns;
  logic [8:0] elapsed_sum;

  // requested offset in ns, one step per phase unit
  assign ph_ns = 8'(phase_steps * PHASE_STEP_NS); // see R5
  assign elapsed_sum = {1'b0, elapsed_r} + 9'(CLK_PERIOD_NS);

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    elapsed_nxt = elapsed_r;
    wid_nxt = wid_r;
    pulse_nxt = 1'b0;
    case (state_r)
      SFDP_IDLE: begin
        if (speed_ok && frame_active && sfd_strobe) begin // see R1, see R3, see R4
          elapsed_nxt = 8'h00;
          if (ph_ns == 8'h00) begin
            state_nxt = SFDP_PULSE;
            pulse_nxt = 1'b1;
            wid_nxt = 2'(PULSE_WIDTH_CYC - 1);
          end else begin
            state_nxt = SFDP_WAIT;
          end
        end
      end
      SFDP_WAIT: begin
        if (!speed_ok) begin
          state_nxt = SFDP_IDLE; // slow mode drops a pending pulse
        end else if (elapsed_sum >= {1'b0, ph_ns}) begin // see R5
          state_nxt = SFDP_PULSE;
          pulse_nxt = 1'b1;
          wid_nxt = 2'(PULSE_WIDTH_CYC - 1);
        end else begin
          elapsed_nxt = elapsed_sum[7:0];
        end
      end
      SFDP_PULSE: begin
        if (wid_r != 2'h0) begin // see R7
          pulse_nxt = 1'b1;
          wid_nxt = wid_r - 2'h1;
        end else begin
          state_nxt = SFDP_DONE;
        end
      end
      SFDP_DONE: begin
        if (!frame_active || !speed_ok) begin // rearm after frame end or when fast mode drops, see R7
          state_nxt = SFDP_IDLE;
        end
      end
      default: state_nxt = SFDP_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SFDP_IDLE;
      elapsed_r <= 8'h00;
      wid_r <= 2'h0;
      pulse_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      elapsed_r <= elapsed_nxt;
      wid_r <= wid_nxt;
      pulse_o <= pulse_nxt;
      busy_o <= (state_nxt != SFDP_IDLE);
    end
  end

  property p_r1;
    @(posedge aclk) disable iff (!aresetn) $rose(pulse_o) |-> $past(speed_ok);
  endproperty
  a_r1: assert property (p_r1) else $error("pulse began outside fast mode"); // see R1

  property p_r3;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SFDP_IDLE && speed_ok && frame_active && sfd_strobe && phase_steps == 4'h0)
      |=> $rose(pulse_o);
  endproperty
  a_r3: assert property (p_r3) else $error("zero phase pulse not next cycle"); // see R3, see R4

  property p_r5;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SFDP_WAIT && speed_ok && elapsed_sum >= {1'b0, ph_ns}) |=> $rose(pulse_o);
  endproperty
  a_r5: assert property (p_r5) else $error("phase delay overran"); // see R5

  property p_r5_early;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SFDP_WAIT) |-> (elapsed_r < ph_ns) && !pulse_o;
  endproperty
  a_r5_early: assert property (p_r5_early) else $error("pulse before phase delay"); // see R5

  property p_r7;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pulse_o) |=> pulse_o ##1 !pulse_o;
  endproperty
  a_r7: assert property (p_r7) else $error("pulse width not two cycles"); // see R7

  property p_r7_once;
    @(posedge aclk) disable iff (!aresetn)
      (state_r == SFDP_DONE && frame_active && speed_ok) |=> !pulse_o [*2];
  endproperty
  a_r7_once: assert property (p_r7_once) else $error("second pulse in one frame"); // see R7
endmodule
`default_nettype wire

// ### hdl/sfdp_timestamp_pulse_gen.sv
// sfdp_timestamp_pulse_gen: SFD timing pulses for tx and rx, routed to pins
// assumes the datapath supplies strobes at the line-side delimiter instants
//
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
// Functional notes
// R1: pulse on tx and rx delimiter, fast mode only
// R2: pin-select register routes pulse to pins
// R3: tx pulse marks delimiter driven onto line
// R4: rx pulse marks first bit of /J/
// R5: phase register delays pulse 8 ns per step
// R6: both registers read and write by software
// R7: one fixed pulse per frame, idle otherwise
module sfdp_timestamp_pulse_gen
  import sfdp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // datapath events
  input wire logic speed_100,
  input wire logic tx_frame_active,
  input wire logic tx_sfd_on_line,
  input wire logic rx_frame_active,
  input wire logic rx_j_first_bit,
  // pulse pins
  output logic [NUM_PINS-1:0] sfd_pulse_pin
);
  // register index of a byte address
  function automatic logic [7:0] reg_index(input logic [AXI_ADDR_W-1:0] addr);
    reg_index = addr[AXI_ADDR_W-1:2];
  endfunction

  // does a two-bit pin field select pin k
  function automatic logic route_hit(input logic [1:0] sel, input int k);
    route_hit = (sel == 2'(k));
  endfunction

  logic [15:0] pin_sel_r, pin_sel_nxt;
  logic [15:0] phase_cfg_r, phase_cfg_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] wr_idx_r, wr_idx_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [1:0] wstrb_r, wstrb_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt;
  logic [1:0] bresp_nxt;
  logic arready_nxt, rvalid_nxt;
  logic [AXI_DATA_W-1:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  logic [NUM_PINS-1:0] pin_nxt;
  logic aw_take, w_take, ar_take, wr_do;
  logic [NUM_PATHS-1:0] path_pulse, path_busy, path_frame, path_strobe;
  logic [15:0] status_word;

  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign ar_take = arvalid && arready;
  assign wr_do = aw_have_r && w_have_r && !bvalid;
  assign status_word = {13'h0000, path_busy[1], path_busy[0], speed_100};

  // write channel: address and data in either order, response after both
  always_comb begin
    aw_have_nxt = aw_have_r || aw_take;
    w_have_nxt = w_have_r || w_take;
    wr_idx_nxt = aw_take ? reg_index(awaddr) : wr_idx_r;
    wdata_nxt = w_take ? wdata[15:0] : wdata_r;
    wstrb_nxt = w_take ? wstrb[1:0] : wstrb_r;
    bvalid_nxt = bvalid && !bready;
    bresp_nxt = bresp;
    pin_sel_nxt = pin_sel_r;
    phase_cfg_nxt = phase_cfg_r;
    if (wr_do) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (wr_idx_r)
        IDX_PIN_SELECT: begin // see R6
          pin_sel_nxt[7:0] = wstrb_r[0] ? wdata_r[7:0] : pin_sel_r[7:0];
          pin_sel_nxt[15:8] = wstrb_r[1] ? wdata_r[15:8] : pin_sel_r[15:8];
        end
        IDX_PHASE_CONFIG: begin // see R6
          phase_cfg_nxt[7:0] = wstrb_r[0] ? wdata_r[7:0] : phase_cfg_r[7:0];
          phase_cfg_nxt[15:8] = wstrb_r[1] ? wdata_r[15:8] : phase_cfg_r[15:8];
        end
        IDX_STATUS: bresp_nxt = RESP_OKAY; // read-only, write ignored
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt = !w_have_nxt;
  end

  // write channel and register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      pin_sel_r <= PIN_SELECT_RST;
      phase_cfg_r <= PHASE_CONFIG_RST;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      wr_idx_r <= wr_idx_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready <= awready_nxt;
      wready <= wready_nxt;
      bvalid <= bvalid_nxt;
      bresp <= bresp_nxt;
      pin_sel_r <= pin_sel_nxt;
      phase_cfg_r <= phase_cfg_nxt;
    end
  end

  // read channel: answer one cycle after the address is taken
  always_comb begin
    rvalid_nxt = rvalid && !rready;
    rdata_nxt = rdata;
    rresp_nxt = rresp;
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (reg_index(araddr))
        IDX_PIN_SELECT: rdata_nxt = {16'h0000, pin_sel_r}; // see R6
        IDX_PHASE_CONFIG: rdata_nxt = {16'h0000, phase_cfg_r}; // see R6
        IDX_STATUS: rdata_nxt = {16'h0000, status_word};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt && !ar_take;
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arready_nxt;
      rvalid <= rvalid_nxt;
      rdata <= rdata_nxt;
      rresp <= rresp_nxt;
    end
  end

  // path 0 is transmit, path 1 is receive
  assign path_frame = {rx_frame_active, tx_frame_active};
  assign path_strobe = {rx_j_first_bit, tx_sfd_on_line}; // see R3, see R4

  // one delay sequencer per path
  for (genvar g = 0; g < NUM_PATHS; g++) begin : g_path
    sfdp_pulse_delay u_delay (
      .aclk(aclk),
      .aresetn(aresetn),
      .speed_ok(speed_100),
      .frame_active(path_frame[g]),
      .sfd_strobe(path_strobe[g]),
      .phase_steps(phase_cfg_r[PHASE_LSB +: 4]),
      .pulse_o(path_pulse[g]),
      .busy_o(path_busy[g])
    );
  end

  // pin routing, a pin may carry both paths
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    assign pin_nxt[k] = (path_pulse[0] && route_hit(pin_sel_r[TX_SEL_LSB +: 2], k)) ||
                        (path_pulse[1] && route_hit(pin_sel_r[RX_SEL_LSB +: 2], k)); // see R2
  end

  // pin registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sfd_pulse_pin <= '0;
    end else begin
      sfd_pulse_pin <= pin_nxt;
    end
  end

  property p_r2;
    @(posedge aclk) disable iff (!aresetn)
      path_pulse[0] |=> sfd_pulse_pin[$past(pin_sel_r[TX_SEL_LSB +: 2])];
  endproperty
  a_r2: assert property (p_r2) else $error("tx pulse missing on selected pin"); // see R2

  property p_r6;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && reg_index(araddr) == IDX_PHASE_CONFIG)
      |=> rvalid && rdata[15:0] == $past(phase_cfg_r) && rresp == RESP_OKAY;
  endproperty
  a_r6: assert property (p_r6) else $error("phase register readback wrong"); // see R6

  property p_r1_idle;
    @(posedge aclk) disable iff (!aresetn)
      !speed_100 [*4] |-> sfd_pulse_pin == '0;
  endproperty
  a_r1_idle: assert property (p_r1_idle) else $error("pin active in slow mode"); // see R1, see R7
endmodule
`default_nettype wire

// ### testbench/sfdp_pulse_sampler.sv
// sfdp_pulse_sampler: timestamp unit model that tallies pulses on the pins
// assumes pins are synchronous to aclk and active high
`default_nettype none
module sfdp_pulse_sampler
  import sfdp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sampled pins
  input wire logic [NUM_PINS-1:0] sfd_pulse_pin,
  // tally
  output logic [7:0] pulse_total
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_PINS-1:0] prev_r;
  // one timestamp per rising edge on any pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= '0;
      pulse_total <= 8'h00;
    end else begin
      prev_r <= sfd_pulse_pin;
      pulse_total <= pulse_total + 8'($countones(sfd_pulse_pin & ~prev_r));
    end
  end
endmodule
`default_nettype wire

// ### testbench/sfdp_timestamp_pulse_gen_bench.sv
// sfdp_timestamp_pulse_gen_bench: register and pulse timing checks
// assumes the sampler model on the pins and a 50 MHz clock
`default_nettype none
module sfdp_timestamp_pulse_gen_bench
  import sfdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, speed_100;
  logic tx_frame_active, tx_sfd_on_line, rx_frame_active, rx_j_first_bit;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NUM_PINS-1:0] sfd_pulse_pin;
  logic [7:0] pulse_total;
  int fail_count = 0, n_checks = 0, exp_pulses = 0, cyc_count = 0;
  int phases [5] = '{1, 2, 3, 7, 15};
  sfdp_timestamp_pulse_gen dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .speed_100(speed_100),
    .tx_frame_active(tx_frame_active), .tx_sfd_on_line(tx_sfd_on_line),
    .rx_frame_active(rx_frame_active), .rx_j_first_bit(rx_j_first_bit),
    .sfd_pulse_pin(sfd_pulse_pin));
  sfdp_pulse_sampler sampler_u (.aclk(aclk), .aresetn(aresetn),
    .sfd_pulse_pin(sfd_pulse_pin), .pulse_total(pulse_total));
  // clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  always @(posedge aclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 4000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] data, input logic [1:0] er);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= data;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && awready) begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready) begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask
  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask
  // one-cycle delimiter strobe inside a frame
  task automatic fire(input bit path);
    @(posedge aclk);
    if (path) rx_frame_active <= 1'b1;
    else tx_frame_active <= 1'b1;
    rx_j_first_bit <= path;
    tx_sfd_on_line <= !path;
    @(posedge aclk);
    rx_j_first_bit <= 1'b0;
    tx_sfd_on_line <= 1'b0;
  endtask
  // pins high exactly two cycles, d cycles after the base latency
  task automatic watch(input int d, input logic [NUM_PINS-1:0] mask);
    logic [NUM_PINS-1:0] e;
    for (int i = 1; i <= d + 5; i++) begin
      @(posedge aclk);
      #1;
      e = (i == d + 1 || i == d + 2) ? mask : '0;
      chk(32'(sfd_pulse_pin), 32'(e), "pins");
    end
    if (mask != '0) exp_pulses++;
  endtask
  task automatic end_frame();
    @(posedge aclk);
    tx_frame_active <= 1'b0;
    rx_frame_active <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // main sequence
  initial begin
    int q;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {tx_frame_active, tx_sfd_on_line, rx_frame_active, rx_j_first_bit} = 4'h0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    speed_100 = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(IDX_PIN_SELECT, 32'(PIN_SELECT_RST), RESP_OKAY);
    axi_rd(IDX_PHASE_CONFIG, 32'(PHASE_CONFIG_RST), RESP_OKAY);
    axi_rd(IDX_STATUS, 32'h0000_0001, RESP_OKAY);
    fire(1'b0);
    watch(0, 4'h1);
    fire(1'b0);
    watch(0, 4'h0);
    end_frame();
    fire(1'b1);
    watch(0, 4'h2);
    end_frame();
    for (int p = 0; p < NUM_PINS; p++) begin
      q = (p + 1) % NUM_PINS;
      axi_wr(IDX_PIN_SELECT, 32'(p + 4 * q), RESP_OKAY);
      fire(1'b0);
      watch(0, 4'(1 << p));
      fire(1'b1);
      watch(0, 4'(1 << q));
      end_frame();
    end
    axi_wr(IDX_PIN_SELECT, 32'h0000_0004, RESP_OKAY);
    foreach (phases[k]) begin
      axi_wr(IDX_PHASE_CONFIG, 32'(phases[k]), RESP_OKAY);
      axi_rd(IDX_PHASE_CONFIG, 32'(phases[k]), RESP_OKAY);
      fire(1'b0);
      watch((phases[k] * PHASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS, 4'h1);
      end_frame();
    end
    speed_100 <= 1'b0;
    axi_rd(IDX_STATUS, 32'h0000_0000, RESP_OKAY);
    fire(1'b0);
    watch(6, 4'h0);
    end_frame();
    speed_100 <= 1'b1;
    axi_wr(IDX_PIN_SELECT, 32'hFFFF_BEE4, RESP_OKAY);
    axi_rd(IDX_PIN_SELECT, 32'h0000_BEE4, RESP_OKAY);
    wstrb <= 4'h1;
    axi_wr(IDX_PIN_SELECT, 32'h0000_1234, RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(IDX_PIN_SELECT, 32'h0000_BE34, RESP_OKAY);
    axi_wr(IDX_STATUS, 32'h0000_0006, RESP_OKAY);
    axi_rd(IDX_STATUS, 32'h0000_0001, RESP_OKAY);
    axi_wr(8'h10, 32'h0000_0001, RESP_SLVERR);
    axi_rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    chk(32'(pulse_total), 32'(exp_pulses), "pulse tally");
    complete_run();
  end
endmodule
`default_nettype wire
